// *** design/can_ctrl_pkg.sv ***
/*
  Shared constants of the CAN control, acceptance filter and identifier block.
  Assumes an 8-bit register port with byte addresses and 8-bit data.
*/
package can_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] ADDR_MAIN_CTL = 8'h00;
  localparam logic [7:0] ADDR_TX_ERR   = 8'h01;
  localparam logic [7:0] ADDR_RX_STAT  = 8'h02;
  localparam logic [7:0] ADDR_ACC_BASE = 8'h08;
  localparam logic [7:0] ADDR_MSK_BASE = 8'h0c;
  localparam logic [7:0] ADDR_RXBUF    = 8'h20;
  localparam logic [7:0] ADDR_TXBUF    = 8'h30;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the main control register, the receive status flag and the IDE bit.
  localparam int BIT_FRM    = 7;
  localparam int BIT_RECEIVER_ACTIVE  = 6;
  localparam int BIT_STOPW  = 5;
  localparam int BIT_SYNC   = 4;
  localparam int BIT_TIMER  = 3;
  localparam int BIT_WAKE   = 2;
  localparam int BIT_SLEEP  = 1;
  localparam int BIT_INIT   = 0;
  localparam int BIT_RXFULL = 0;
  localparam int BIT_IDE    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and buffer layout.
  localparam logic [7:0] MAIN_CTL_RESET = 8'h01;
  localparam logic [7:0] ACC_RESET      = 8'h00;
  localparam logic [7:0] MSK_RESET      = 8'h00;
  localparam logic [3:0] TS_HI_BYTE     = 4'he;
  localparam logic [3:0] TS_LO_BYTE     = 4'hf;
  localparam int         BUF_BYTES      = 16;
  localparam int         ID_BYTES       = 4;

endpackage

// *** design/can_accept_filter.sv ***
/*
  Identifier acceptance filter: compares four identifier bytes with the
  acceptance and mask bytes. Purely combinational; the caller registers it.
  Assumes mask bit 1 means the bit is ignored.
*/
`timescale 1ns/100ps
module can_accept_filter (
  // Identifier bytes of the frame under test.
  input  wire logic [3:0][7:0] id_bytes,
  // Acceptance and mask bytes.
  input  wire logic [3:0][7:0] acc_bytes,
  input  wire logic [3:0][7:0] msk_bytes,
  // Result.
  output logic                 hit
);

  logic [3:0] byte_match;
  logic       is_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Each byte matches when every unmasked bit equals its acceptance bit.
  genvar g;
  generate
    for (g = 0; g < can_ctrl_pkg::ID_BYTES; g++) begin : g_byte
      assign byte_match[g] = ~|((id_bytes[g] ^ acc_bytes[g]) & ~msk_bytes[g]);
    end
  endgenerate

  // Extended frames use all four pairs, standard frames only the first two.
  assign is_ext = id_bytes[1][can_ctrl_pkg::BIT_IDE];
  assign hit    = is_ext ? &byte_match : &byte_match[1:0];

endmodule

// *** design/can_ctrl_filter_idmap.sv ***
/*
  CAN controller control/status, acceptance registers, timestamp timer and
  message buffers. Assumes a protocol engine beside it that delivers receive
  bytes, frame events, bit ticks and status levels, all synchronous to clk.
*/
`timescale 1ns/100ps
module can_ctrl_filter_idmap (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Protocol engine status.
  input  wire logic        init_acknowledge,
  input  wire logic        sleep_acknowledge,
  input  wire logic        rx_busy,
  input  wire logic        bus_synced_in,
  input  wire logic        bus_traffic,
  input  wire logic        bit_tick,
  input  wire logic [7:0]  tx_error_counter,
  // Receive byte stream and frame events.
  input  wire logic        rx_byte_wr,
  input  wire logic [3:0]  rx_byte_idx,
  input  wire logic [7:0]  rx_byte_data,
  input  wire logic        rx_frame_valid,
  input  wire logic        msg_acked,
  input  wire logic        msg_acked_tx,
  // Transmit buffer side.
  input  wire logic        tx_buffer_empty_flag,
  input  wire logic        tx_buffer_select,
  input  wire logic [3:0]  tx_rd_idx,
  output logic      [7:0]  tx_rd_data,
  // System wait mode.
  input  wire logic        sys_wait,
  // Control outputs.
  output logic             init_request,
  output logic             sleep_request,
  output logic             bus_clk_en,
  output logic             wake_request,
  output logic             rx_accept,
  output logic             rx_buffer_full_flag
);

  typedef struct packed {
    logic            frm;
    logic            rx_act;
    logic            stop_wait;
    logic            synced;
    logic            timer_en;
    logic            wake_en;
    logic            sleep_req;
    logic            init_req;
    logic [15:0]     timer;
    logic [3:0][7:0] acc;
    logic [3:0][7:0] msk;
    logic            rx_full;
    logic [7:0]      rdata;
    logic            clk_en;
    logic            wake_pulse;
    logic            accept_pulse;
  } state_t;

  state_t          st_r;
  state_t          st_nxt;
  logic [7:0]      bg_buf [16];
  logic [7:0]      fg_buf [16];
  logic [7:0]      tx_buf [16];
  logic [7:0]      tx_rd_r;
  logic [3:0][7:0] bg_id;
  logic            filt_hit;
  logic            init_mode;
  logic            ctl_wr;
  logic            acc_wr;
  logic            msk_wr;
  logic            rxb_sel;
  logic            txb_sel;
  logic            tx_wr_ok;
  logic            copy_fg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of modes and register strobes.
  assign init_mode = st_r.init_req & init_acknowledge;
  assign ctl_wr    = reg_wr && reg_addr == can_ctrl_pkg::ADDR_MAIN_CTL;
  assign acc_wr    = reg_wr && reg_addr[7:2] == can_ctrl_pkg::ADDR_ACC_BASE[7:2];
  assign msk_wr    = reg_wr && reg_addr[7:2] == can_ctrl_pkg::ADDR_MSK_BASE[7:2];
  assign rxb_sel   = reg_addr[7:4] == can_ctrl_pkg::ADDR_RXBUF[7:4];
  assign txb_sel   = reg_addr[7:4] == can_ctrl_pkg::ADDR_TXBUF[7:4];
  assign tx_wr_ok  = reg_wr && txb_sel && tx_buffer_empty_flag && tx_buffer_select;
  assign copy_fg   = rx_frame_valid && filt_hit && !st_r.rx_full;

  // Identifier bytes of the frame held in the background buffer.
  genvar g;
  generate
    for (g = 0; g < can_ctrl_pkg::ID_BYTES; g++) begin : g_id
      assign bg_id[g] = bg_buf[g];
    end
  endgenerate

  // Acceptance check of the background frame.
  can_accept_filter u_filter (
    .id_bytes  (bg_id),
    .acc_bytes (st_r.acc),
    .msk_bytes (st_r.msk),
    .hit       (filt_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of control, status, timer and filter registers.
  always_comb begin
    st_nxt = st_r;
    st_nxt.wake_pulse   = 1'b0;
    st_nxt.accept_pulse = 1'b0;
    st_nxt.rdata        = 8'h00;
    // Status levels follow the engine outside initialization mode; they never take writes.
    st_nxt.rx_act = rx_busy;
    st_nxt.synced = bus_synced_in;
    // Software writes to the main control register.
    if (ctl_wr) begin
      st_nxt.init_req = reg_wdata[can_ctrl_pkg::BIT_INIT];
      if (!st_r.init_req && !init_acknowledge) begin
        st_nxt.stop_wait = reg_wdata[can_ctrl_pkg::BIT_STOPW];
        st_nxt.timer_en  = reg_wdata[can_ctrl_pkg::BIT_TIMER];
        st_nxt.wake_en   = reg_wdata[can_ctrl_pkg::BIT_WAKE];
        st_nxt.sleep_req = reg_wdata[can_ctrl_pkg::BIT_SLEEP];
        if (reg_wdata[can_ctrl_pkg::BIT_FRM]) begin
          st_nxt.frm = 1'b0;
        end
      end
    end
    // A valid frame sets the flag and wins over a clear in the same cycle.
    // No loopback path exists in this block, so the flag is always meaningful.
    if (rx_frame_valid) begin
      st_nxt.frm = 1'b1;
    end
    // Traffic ends sleep only when wake-up is enabled.
    if (st_r.sleep_req && sleep_acknowledge && st_r.wake_en && bus_traffic) begin
      st_nxt.sleep_req  = 1'b0;
      st_nxt.wake_pulse = 1'b1;
    end
    // Free-running timestamp timer on bit clock ticks.
    // It wraps silently at 16 bits; software only sees it through the stamps.
    if (!st_r.timer_en) begin
      st_nxt.timer = 16'h0000;
    end else if (bit_tick) begin
      st_nxt.timer = st_r.timer + 16'h0001;
    end
    // Acceptance and mask bytes only change in initialization mode.
    if (init_mode && acc_wr) begin
      st_nxt.acc[reg_addr[1:0]] = reg_wdata;
    end
    if (init_mode && msk_wr) begin
      st_nxt.msk[reg_addr[1:0]] = reg_wdata;
    end
    // Receive full flag: accepted frames set it, a written one clears it.
    // A full foreground buffer drops new frames so the one being read stays whole.
    if (reg_wr && reg_addr == can_ctrl_pkg::ADDR_RX_STAT
        && reg_wdata[can_ctrl_pkg::BIT_RXFULL]) begin
      st_nxt.rx_full = 1'b0;
    end
    if (copy_fg) begin
      st_nxt.rx_full      = 1'b1;
      st_nxt.accept_pulse = 1'b1;
    end
    // Initialization mode holds the register at reset except three bits.
    if (init_mode) begin
      st_nxt.frm       = 1'b0;
      st_nxt.rx_act    = 1'b0;
      st_nxt.stop_wait = 1'b0;
      st_nxt.synced    = 1'b0;
      st_nxt.timer_en  = 1'b0;
    end
    // Clock gate for the CPU bus interface in wait mode.
    st_nxt.clk_en = !(st_nxt.stop_wait && sys_wait);
    // Read data, valid the cycle after the strobe; unmapped reads zero.
    if (reg_rd) begin
      if (reg_addr == can_ctrl_pkg::ADDR_MAIN_CTL) begin
        st_nxt.rdata = {st_r.frm, st_r.rx_act, st_r.stop_wait, st_r.synced,
                        st_r.timer_en, st_r.wake_en, st_r.sleep_req,
                        st_r.init_req};
      end else if (reg_addr == can_ctrl_pkg::ADDR_TX_ERR) begin
        st_nxt.rdata = tx_error_counter;
      end else if (reg_addr == can_ctrl_pkg::ADDR_RX_STAT) begin
        st_nxt.rdata = {7'h00, st_r.rx_full};
      end else if (reg_addr[7:2] == can_ctrl_pkg::ADDR_ACC_BASE[7:2]) begin
        st_nxt.rdata = st_r.acc[reg_addr[1:0]];
      end else if (reg_addr[7:2] == can_ctrl_pkg::ADDR_MSK_BASE[7:2]) begin
        st_nxt.rdata = st_r.msk[reg_addr[1:0]];
      end else if (rxb_sel && st_r.rx_full) begin
        st_nxt.rdata = fg_buf[reg_addr[3:0]];
      end else if (txb_sel) begin
        st_nxt.rdata = tx_buf[reg_addr[3:0]];
      end
    end
  end

  // State register; the main control register resets to its printed value.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.init_req  <= can_ctrl_pkg::MAIN_CTL_RESET[can_ctrl_pkg::BIT_INIT];
      st_r.acc       <= {4{can_ctrl_pkg::ACC_RESET}};
      st_r.msk       <= {4{can_ctrl_pkg::MSK_RESET}};
      st_r.clk_en    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message buffers are plain RAM with no reset value.
  // Background, foreground and transmit buffers; the timestamp lands high
  // byte first in the buffer that the acknowledged frame used.
  always_ff @(posedge clk) begin
    if (rx_byte_wr) begin
      bg_buf[rx_byte_idx] <= rx_byte_data;
    end
    if (msg_acked && st_r.timer_en && !msg_acked_tx) begin
      bg_buf[can_ctrl_pkg::TS_HI_BYTE] <= st_r.timer[15:8];
      bg_buf[can_ctrl_pkg::TS_LO_BYTE] <= st_r.timer[7:0];
    end
    if (copy_fg) begin
      for (int i = 0; i < can_ctrl_pkg::BUF_BYTES; i++) begin
        fg_buf[i] <= bg_buf[i];
      end
    end
    if (tx_wr_ok) begin
      tx_buf[reg_addr[3:0]] <= reg_wdata;
    end
    if (msg_acked && st_r.timer_en && msg_acked_tx) begin
      tx_buf[can_ctrl_pkg::TS_HI_BYTE] <= st_r.timer[15:8];
      tx_buf[can_ctrl_pkg::TS_LO_BYTE] <= st_r.timer[7:0];
    end
    tx_rd_r <= tx_buf[tx_rd_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops.
  assign reg_rdata           = st_r.rdata;
  assign init_request        = st_r.init_req;
  assign sleep_request       = st_r.sleep_req;
  assign bus_clk_en          = st_r.clk_en;
  assign wake_request        = st_r.wake_pulse;
  assign rx_accept           = st_r.accept_pulse;
  assign rx_buffer_full_flag = st_r.rx_full;
  assign tx_rd_data          = tx_rd_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks of the control behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_init_hold: assert property (init_mode |=> !st_r.timer_en && !st_r.stop_wait)
    else $error("Control bits not held in initialization mode.");
  chk_frm_set: assert property (rx_frame_valid |=> st_r.frm [*1])
    else $error("Frame flag not set by valid frame.");
  chk_frm_clear: assert property (ctl_wr && !init_mode && !st_r.init_req && !init_acknowledge
      && reg_wdata[7] && !rx_frame_valid |=> !st_r.frm)
    else $error("Frame flag not cleared by writing one.");
  chk_frm_keep: assert property (st_r.frm && ctl_wr && !reg_wdata[7] && !init_mode
      |=> st_r.frm)
    else $error("Writing zero changed the frame flag.");
  chk_rx_status: assert property (rx_busy && !init_mode
      |=> st_r.rx_act)
    else $error("Receiver status does not follow the engine.");
  chk_clk_gate: assert property (st_r.stop_wait && sys_wait && !init_mode && !ctl_wr
      |=> !bus_clk_en)
    else $error("Bus clock not stopped in wait mode.");
  chk_timer_zero: assert property (!st_r.timer_en |=> st_r.timer == 16'h0000)
    else $error("Disabled timer is not zero.");
  chk_timer_step: assert property (st_r.timer_en && bit_tick && !init_mode && !ctl_wr
      |=> st_r.timer == $past(st_r.timer) + 16'h0001)
    else $error("Timer did not step on a bit tick.");
  chk_acc_lock: assert property (acc_wr && !init_mode |=> $stable(st_r.acc))
    else $error("Acceptance byte written outside initialization mode.");
  chk_accept_out: assert property (copy_fg |=> rx_accept && rx_buffer_full_flag)
    else $error("Accepted frame not signalled.");
  chk_wake_out: assert property (st_r.sleep_req && sleep_acknowledge && st_r.wake_en
      && bus_traffic |=> wake_request && !sleep_request)
    else $error("Bus traffic did not wake from sleep.");

  // Status bits and read data.
  chk_rx_idle: assert property (!rx_busy |=> !st_r.rx_act)
    else $error("Receiver status set while the engine is idle.");
  chk_sync_follow: assert property (!init_mode
      |=> st_r.synced == $past(bus_synced_in))
    else $error("Synced status does not follow the engine.");
  chk_init_flags: assert property (init_mode
      |=> !st_r.frm && !st_r.synced && !st_r.rx_act)
    else $error("Status bits not cleared in initialization mode.");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data not zero outside a read.");
  chk_rxbuf_empty: assert property (reg_rd && rxb_sel && !st_r.rx_full
      |=> reg_rdata == 8'h00)
    else $error("Empty receive buffer returned data.");

  // Mask lock, wait-mode clock and held flags.
  chk_msk_lock: assert property (msk_wr && !init_mode |=> $stable(st_r.msk))
    else $error("Mask byte written outside initialization mode.");
  chk_clk_run: assert property (!sys_wait |=> bus_clk_en)
    else $error("Bus clock stopped outside wait mode.");
  chk_sleep_hold: assert property (st_r.sleep_req && !st_r.wake_en && !ctl_wr
      |=> sleep_request)
    else $error("Sleep ended with wake-up disabled.");
  chk_full_hold: assert property (st_r.rx_full && !(reg_wr
      && reg_addr == can_ctrl_pkg::ADDR_RX_STAT) |=> rx_buffer_full_flag)
    else $error("Receive full flag dropped without a clear.");

  // Main scenarios: acceptance, wake, any stamp, the receive stamp and leaving init.
  cov_accept: cover property (rx_frame_valid ##1 rx_accept);
  cov_wake: cover property (sleep_request ##1 wake_request);
  cov_stamp: cover property (st_r.timer_en && msg_acked);
  cov_init_exit: cover property (init_mode ##1 !st_r.init_req);
  cov_rx_stamp: cover property (st_r.timer_en && msg_acked && !msg_acked_tx);

endmodule

// *** sim/can_engine_model.sv ***
/*
  Behavioural protocol engine standing in for the bus side of the control block.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/100ps
module can_engine_model #(
  parameter logic [7:0] ERR_COUNT = 8'h2c
) (
  // Clock and mode requests from the block.
  input  wire logic       clk,
  input  wire logic       init_request,
  input  wire logic       sleep_request,
  // Engine status levels.
  output logic            init_acknowledge,
  output logic            sleep_acknowledge,
  output logic            rx_busy,
  output logic            bus_synced_in,
  output logic            bus_traffic,
  output logic            bit_tick,
  output logic      [7:0] tx_error_counter,
  // Receive stream and frame events.
  output logic            rx_byte_wr,
  output logic      [3:0] rx_byte_idx,
  output logic      [7:0] rx_byte_data,
  output logic            rx_frame_valid,
  output logic            msg_acked,
  output logic            msg_acked_tx,
  // Transmit buffer side.
  output logic            tx_buffer_empty_flag,
  output logic            tx_buffer_select,
  output logic      [3:0] tx_rd_idx,
  output logic            tx_peek
);
  ////////////////////////////////////////////////////////////////////////////
  // The engine starts idle and synced, with the transmit buffer free.
  initial begin
    {rx_busy, bus_traffic, bit_tick, rx_byte_wr, rx_frame_valid} = '0;
    {msg_acked, msg_acked_tx, tx_peek, rx_byte_idx, rx_byte_data} = '0;
    {bus_synced_in, tx_buffer_empty_flag, tx_buffer_select} = 3'h7;
    tx_error_counter = ERR_COUNT;
    tx_rd_idx = 4'h0;
  end

  // Mode acknowledges trail the requests by one cycle, as a real engine would.
  always @(posedge clk) begin
    init_acknowledge  <= init_request;
    sleep_acknowledge <= sleep_request;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sets the status and buffer gating levels together.
  task automatic levels(input logic busy, input logic synced, input logic empty,
                        input logic sel);
    rx_busy              <= busy;
    bus_synced_in        <= synced;
    tx_buffer_empty_flag <= empty;
    tx_buffer_select     <= sel;
  endtask

  // Loads a new transmit error count.
  task automatic set_err(input logic [7:0] v);
    tx_error_counter <= v;
  endtask

  // Sends four identifier bytes, then the valid pulse; the data line toggles in that same cycle.
  task automatic send_frame(input logic [3:0][7:0] id);
    for (int i = 0; i < 4; i++) begin
      rx_byte_wr   <= 1'b1;
      rx_byte_idx  <= i[3:0];
      rx_byte_data <= id[i];
      @(posedge clk);
    end
    rx_byte_wr     <= 1'b0;
    rx_byte_data   <= ~id[3];
    rx_frame_valid <= 1'b1;
    @(posedge clk);
    rx_frame_valid <= 1'b0;
    @(posedge clk);
  endtask

  // Emits a number of bit-time pulses with a gap between them.
  task automatic ticks(input int n);
    repeat (n) begin
      bit_tick <= 1'b1;
      @(posedge clk);
      bit_tick <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Reports an acknowledged frame; tx picks the transmit buffer for the stamp.
  task automatic ack(input logic tx);
    msg_acked    <= 1'b1;
    msg_acked_tx <= tx;
    @(posedge clk);
    msg_acked    <= 1'b0;
    msg_acked_tx <= 1'b0;
    @(posedge clk);
  endtask

  // Reads one transmit buffer byte and marks the look for the bench.
  task automatic peek(input logic [3:0] idx);
    tx_rd_idx <= idx;
    tx_peek   <= 1'b1;
    @(posedge clk);
    tx_rd_idx <= ~idx;
    tx_peek   <= 1'b0;
    @(posedge clk);
  endtask

  // Shows one cycle of bus activity.
  task automatic traffic();
    bus_traffic <= 1'b1;
    @(posedge clk);
    bus_traffic <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// *** sim/can_ctrl_filter_idmap_tb_top.sv ***
/*
  Self-checking bench for the control, filter and identifier block.
  Assumes the engine model drives every engine-side input of the block.
*/
`timescale 1ns/100ps
`define CHECK(act, exp) begin \
  compares++; \
  if ((act) !== (exp)) begin \
    bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, act, exp); \
  end \
end
module can_ctrl_filter_idmap_tb_top;
  localparam logic [7:0] ERR = 8'h2c;
  logic clk, reset, reg_wr, reg_rd, init_request, sleep_request, bus_clk_en;
  logic wake_request, rx_accept, rx_buffer_full_flag, sys_wait, init_acknowledge;
  logic sleep_acknowledge, rx_busy, bus_synced_in, bus_traffic, bit_tick, rx_byte_wr;
  logic rx_frame_valid, msg_acked, msg_acked_tx, tx_buffer_empty_flag, tx_buffer_select;
  logic tx_peek, rd_d, fv_d, tp_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_error_counter, rx_byte_data, tx_rd_data;
  logic [7:0] got, exp_v;
  logic [3:0] rx_byte_idx, tx_rd_idx;
  logic [7:0] exp_q[$];
  int         bad_count, compares, wake_cnt;

  can_ctrl_filter_idmap can_ctrl_filter_idmap_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .init_acknowledge(init_acknowledge), .sleep_acknowledge(sleep_acknowledge),
    .rx_busy(rx_busy), .bus_synced_in(bus_synced_in), .bus_traffic(bus_traffic),
    .bit_tick(bit_tick), .tx_error_counter(tx_error_counter), .rx_byte_wr(rx_byte_wr),
    .rx_byte_idx(rx_byte_idx), .rx_byte_data(rx_byte_data), .rx_frame_valid(rx_frame_valid),
    .msg_acked(msg_acked), .msg_acked_tx(msg_acked_tx),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_buffer_select(tx_buffer_select),
    .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data), .sys_wait(sys_wait),
    .init_request(init_request), .sleep_request(sleep_request), .bus_clk_en(bus_clk_en),
    .wake_request(wake_request), .rx_accept(rx_accept),
    .rx_buffer_full_flag(rx_buffer_full_flag));

  can_engine_model #(.ERR_COUNT(ERR)) can_engine_model_i (
    .clk(clk), .init_request(init_request), .sleep_request(sleep_request),
    .init_acknowledge(init_acknowledge), .sleep_acknowledge(sleep_acknowledge),
    .rx_busy(rx_busy), .bus_synced_in(bus_synced_in), .bus_traffic(bus_traffic),
    .bit_tick(bit_tick), .tx_error_counter(tx_error_counter), .rx_byte_wr(rx_byte_wr),
    .rx_byte_idx(rx_byte_idx), .rx_byte_data(rx_byte_data), .rx_frame_valid(rx_frame_valid),
    .msg_acked(msg_acked), .msg_acked_tx(msg_acked_tx),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_buffer_select(tx_buffer_select),
    .tx_rd_idx(tx_rd_idx), .tx_peek(tx_peek));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 4 ns clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Takes the oldest note whenever a read, frame verdict or buffer look lands.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    fv_d <= rx_frame_valid;
    tp_d <= tx_peek;
    if (wake_request === 1'b1) wake_cnt <= wake_cnt + 1;
    if (rd_d === 1'b1 || fv_d === 1'b1 || tp_d === 1'b1) begin
      got = rd_d ? reg_rdata : (fv_d ? {7'h00, rx_accept} : tx_rd_data);
      if (exp_q.size() == 0) bad_count++;
      else begin
        exp_v = exp_q.pop_front();
        `CHECK(got, exp_v)
      end
    end
  end

  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles, each followed by one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Prints the verdict once and ends the run.
  task automatic print_verdict();
    if (exp_q.size() != 0) bad_count++;
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [3:0][7:0] acc, fs, fe;
    logic [3:0][7:0] msk;
    logic [7:0]      err_v;
    void'($urandom(85));
    {reset, reg_wr, reg_rd, sys_wait, reg_addr, reg_wdata} = {1'b1, 19'h0};
    {bad_count, compares, wake_cnt} = '0;
    acc = $urandom;
    err_v = 8'($urandom);
    acc[1] = acc[1] & 8'hf0;
    msk = 32'h00000f00;
    fs = {~acc[3], ~acc[2], acc[1][7:4], 4'h5, acc[0]};
    fe = {acc[3], acc[2] ^ 8'h01, acc[1] | 8'h08, acc[0]};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    can_engine_model_i.set_err(err_v);
    @(posedge clk);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, can_ctrl_pkg::MAIN_CTL_RESET);
    `CHECK(init_request, 1'b1)
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h2d);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(can_ctrl_pkg::ADDR_ACC_BASE + 8'(i), acc[i]);
      wr(can_ctrl_pkg::ADDR_MSK_BASE + 8'(i), msk[i]);
      rd(can_ctrl_pkg::ADDR_ACC_BASE + 8'(i), acc[i]);
      rd(can_ctrl_pkg::ADDR_MSK_BASE + 8'(i), msk[i]);
    end
    rd(can_ctrl_pkg::ADDR_TX_ERR, err_v);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h00);
    wr(can_ctrl_pkg::ADDR_ACC_BASE, ~acc[0]);
    rd(can_ctrl_pkg::ADDR_ACC_BASE, acc[0]);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h68);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h38);
    can_engine_model_i.levels(1'b1, 1'b0, 1'b1, 1'b1);
    @(posedge clk);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h68);
    can_engine_model_i.levels(1'b0, 1'b1, 1'b1, 1'b1);
    sys_wait <= 1'b1;
    repeat (3) @(posedge clk);
    `CHECK(bus_clk_en, 1'b0)
    sys_wait <= 1'b0;
    can_engine_model_i.ticks(5);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h05);
    can_engine_model_i.ack(1'b1);
    can_engine_model_i.peek(can_ctrl_pkg::TS_HI_BYTE);
    can_engine_model_i.peek(can_ctrl_pkg::TS_LO_BYTE);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h00);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h08);
    sys_wait <= 1'b1;
    can_engine_model_i.ticks(3);
    `CHECK(bus_clk_en, 1'b1)
    sys_wait <= 1'b0;
    exp_q.push_back(8'h03);
    can_engine_model_i.ack(1'b1);
    can_engine_model_i.peek(can_ctrl_pkg::TS_LO_BYTE);
    wr(can_ctrl_pkg::ADDR_TXBUF + 8'h01, 8'h5a);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(8'h5a);
      can_engine_model_i.peek(4'h1);
      can_engine_model_i.levels(1'b0, 1'b1, i[0], ~i[0]);
      wr(can_ctrl_pkg::ADDR_TXBUF + 8'h01, 8'ha5);
    end
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h18);
    exp_q.push_back(8'h00);
    can_engine_model_i.send_frame(fe);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h98);
    exp_q.push_back(8'h01);
    can_engine_model_i.send_frame(fs);
    rd(can_ctrl_pkg::ADDR_RX_STAT, 8'h01);
    rd(can_ctrl_pkg::ADDR_RXBUF, fs[0]);
    rd(can_ctrl_pkg::ADDR_RXBUF + 8'h01, fs[1]);
    fe[2] = acc[2];
    exp_q.push_back(8'h00);
    can_engine_model_i.send_frame(fe);
    wr(can_ctrl_pkg::ADDR_RX_STAT, 8'h01);
    rd(can_ctrl_pkg::ADDR_RXBUF, 8'h00);
    can_engine_model_i.ack(1'b0);
    exp_q.push_back(8'h01);
    can_engine_model_i.send_frame(fe);
    rd(can_ctrl_pkg::ADDR_RXBUF + 8'h02, fe[2]);
    rd(can_ctrl_pkg::ADDR_RXBUF + 8'h03, fe[3]);
    rd(can_ctrl_pkg::ADDR_RXBUF + 8'h0e, 8'h00);
    rd(can_ctrl_pkg::ADDR_RXBUF + 8'h0f, 8'h03);
    `CHECK(rx_buffer_full_flag, 1'b1)
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h08);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h98);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h88);
    rd(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h18);
    rd(8'h7f, 8'h00);
    can_engine_model_i.set_err(~err_v);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h04);
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h06);
    rd(can_ctrl_pkg::ADDR_TX_ERR, ~err_v);
    can_engine_model_i.traffic();
    @(posedge clk);
    `CHECK(sleep_request, 1'b0)
    `CHECK(wake_cnt, 1)
    wr(can_ctrl_pkg::ADDR_MAIN_CTL, 8'h02);
    can_engine_model_i.traffic();
    @(posedge clk);
    `CHECK(sleep_request, 1'b1)
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
